// >>> design/qsc_ctrl.sv
// Purpose: Serial clock divider, clock-stable flag, command and interrupt thresholds.
// Assumes: Base clock is clk; register port is word indexed; inputs are synchronous.
// Notes:   The serial rate is a one-cycle enable pulse, not a derived clock.
`timescale 1ns/1ps
`include "qsc_map.svh"

// Overview of operation
// - one-hot divider bit k divides by 2^(k+1)
// - all-zero divider gives undivided fastest rate
// - stable flag sets after enabled clock settles
// - clearing enable stops the serial clock
// - registers stay accessible with clock disabled
// - transmit starts when FIFO reaches threshold
// - receive fills buffer up to threshold
// - no receive without room for threshold
// - reads lowering count trigger more receives
// - transmit condition when free space exceeds threshold
// - receive condition when count reaches threshold
// - unimplemented clock control bits read zero
// - mode codes idle, transmit, receive, reserved
// - transmit threshold sets hardware status flag
module qsc_ctrl #(
	parameter int DEPTH  = `QSC_FIFO_DEPTH,
	parameter int SETTLE = `QSC_SETTLE_TICKS
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  qsc_pkg::qsc_reg_req_t reg_req,
	output logic [31:0]        reg_rdata,
	input  wire logic [1:0]    command_initiation_mode,
	output logic               serial_clock_tick,
	output logic               clock_stable,
	output qsc_pkg::qsc_xfer_t xfer,
	output logic               xfer_start,
	input  wire logic          xfer_done,
	input  wire logic          tx_flag_clr,
	output logic               tx_threshold_flag,
	output logic               tx_irq_cond,
	output logic               rx_irq_cond,
	input  wire logic          sw_tx_valid,
	output logic               sw_tx_ready,
	input  wire logic [7:0]    sw_tx_data,
	output logic               link_tx_valid,
	input  wire logic          link_tx_ready,
	output logic [7:0]         link_tx_data,
	input  wire logic          link_rx_valid,
	output logic               link_rx_ready,
	input  wire logic [7:0]    link_rx_data,
	output logic               sw_rx_valid,
	input  wire logic          sw_rx_ready,
	output logic [7:0]         sw_rx_data
);
	import qsc_pkg::*;

	localparam int         CW     = $clog2(DEPTH + 1);
	localparam logic [7:0] DEPTH8 = 8'(DEPTH);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [`QSC_DIV_W-1:0] serial_clock_divider_r;
	logic                  clk_en_r;
	logic [7:0]            tx_command_threshold_r;
	logic [7:0]            rx_command_threshold_r;
	logic [7:0]            tx_irq_threshold_r;
	logic [7:0]            rx_irq_threshold_r;
	logic                  stable_r;
	logic                  clkcon_wr;

	assign clkcon_wr = reg_req.wr && (reg_req.idx == `QSC_IDX_CLKCON);

	// Writes never depend on the serial clock running.
	always_ff @(posedge clk) begin
		if (rst) begin
			serial_clock_divider_r <= '0;
			clk_en_r               <= 1'b0;
			tx_command_threshold_r <= '0;
			rx_command_threshold_r <= '0;
			tx_irq_threshold_r     <= '0;
			rx_irq_threshold_r     <= '0;
		end else if (reg_req.wr) begin
			case (reg_req.idx)
				`QSC_IDX_CLKCON: begin
					serial_clock_divider_r <= reg_req.wdata[`QSC_DIV_MSB:`QSC_DIV_LSB];
					clk_en_r               <= reg_req.wdata[`QSC_EN_BIT];
				end
				`QSC_IDX_CMDTHR: begin
					tx_command_threshold_r <= reg_req.wdata[`QSC_HI_MSB:`QSC_HI_LSB];
					rx_command_threshold_r <= reg_req.wdata[`QSC_LO_MSB:`QSC_LO_LSB];
				end
				`QSC_IDX_INTTHR: begin
					tx_irq_threshold_r <= reg_req.wdata[`QSC_HI_MSB:`QSC_HI_LSB];
					rx_irq_threshold_r <= reg_req.wdata[`QSC_LO_MSB:`QSC_LO_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = `QSC_RESET_WORD;
		case (reg_req.idx)
			`QSC_IDX_CLKCON: begin
				rd_nxt[`QSC_DIV_MSB:`QSC_DIV_LSB] = serial_clock_divider_r;
				rd_nxt[`QSC_STABLE_BIT]           = stable_r;
				rd_nxt[`QSC_EN_BIT]               = clk_en_r;
			end
			`QSC_IDX_CMDTHR: begin
				rd_nxt[`QSC_HI_MSB:`QSC_HI_LSB] = tx_command_threshold_r;
				rd_nxt[`QSC_LO_MSB:`QSC_LO_LSB] = rx_command_threshold_r;
			end
			`QSC_IDX_INTTHR: begin
				rd_nxt[`QSC_HI_MSB:`QSC_HI_LSB] = tx_irq_threshold_r;
				rd_nxt[`QSC_LO_MSB:`QSC_LO_LSB] = rx_irq_threshold_r;
			end
			default: rd_nxt = `QSC_RESET_WORD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			reg_rdata <= `QSC_RESET_WORD;
		else if (reg_req.rd)
			reg_rdata <= rd_nxt;
	end

	// ****************************************************************
	// Serial clock divider and stable flag
	// ****************************************************************
	logic [`QSC_DIV_W-1:0] div_lim;
	logic [`QSC_DIV_W-1:0] div_cnt_r;
	logic [3:0]            settle_r;

	// Highest set bit wins if software sets more than one.
	always_comb begin
		div_lim = '0;
		for (int i = 0; i < `QSC_DIV_W; i++) begin
			if (serial_clock_divider_r[i])
				div_lim = `QSC_DIV_W'((12'h2 << i) - 12'h1);
		end
	end

	assign serial_clock_tick = clk_en_r && (div_cnt_r >= div_lim);

	always_ff @(posedge clk) begin
		if (rst || !clk_en_r || clkcon_wr)
			div_cnt_r <= '0;
		else if (serial_clock_tick)
			div_cnt_r <= '0;
		else
			div_cnt_r <= div_cnt_r + 1'b1;
	end

	// A write that drops the enable clears the flag on that same edge, so it never outlives the enable.
	always_ff @(posedge clk) begin
		if (rst || !clk_en_r || (clkcon_wr && !reg_req.wdata[`QSC_EN_BIT])) begin
			settle_r <= '0;
			stable_r <= 1'b0;
		end else if (serial_clock_tick && !stable_r) begin
			settle_r <= settle_r + 1'b1;
			stable_r <= (settle_r == 4'(SETTLE - 1));
		end
	end

	assign clock_stable = stable_r;

	// ****************************************************************
	// FIFOs
	// ****************************************************************
	logic [CW-1:0] tx_cnt;
	logic [CW-1:0] rx_cnt;
	logic [7:0]    tx_cnt8;
	logic [7:0]    rx_cnt8;
	logic [7:0]    tx_free8;
	logic [7:0]    rx_free8;

	qsc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (sw_tx_valid),
		.in_ready  (sw_tx_ready),
		.in_data   (sw_tx_data),
		.out_valid (link_tx_valid),
		.out_ready (link_tx_ready),
		.out_data  (link_tx_data),
		.count     (tx_cnt)
	);

	qsc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (link_rx_valid),
		.in_ready  (link_rx_ready),
		.in_data   (link_rx_data),
		.out_valid (sw_rx_valid),
		.out_ready (sw_rx_ready),
		.out_data  (sw_rx_data),
		.count     (rx_cnt)
	);

	assign tx_cnt8  = 8'(tx_cnt);
	assign rx_cnt8  = 8'(rx_cnt);
	assign tx_free8 = DEPTH8 - tx_cnt8;
	assign rx_free8 = DEPTH8 - rx_cnt8;

	// ****************************************************************
	// Command initiation
	// ****************************************************************
	qsc_mode_t  mode;
	qsc_state_t state_r;
	logic       tx_go;
	logic       rx_go;
	logic [7:0] rx_need;

	assign mode    = qsc_mode_t'(command_initiation_mode);
	assign rx_need = rx_command_threshold_r - rx_cnt8;
	assign tx_go   = (mode == mode_tx) && (tx_cnt8 != '0)
		&& (tx_cnt8 >= tx_command_threshold_r);
	// Receive tops the buffer up to the threshold, only if all of it fits.
	assign rx_go   = (mode == mode_rx) && (rx_cnt8 < rx_command_threshold_r)
		&& (rx_free8 >= rx_need);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r    <= st_idle;
			xfer_start <= 1'b0;
			xfer       <= '0;
		end else begin
			xfer_start <= 1'b0;
			case (state_r)
				st_idle: begin
					if (stable_r && tx_go) begin
						xfer_start <= 1'b1;
						xfer       <= '{rx: 1'b0, len: tx_cnt8};
						state_r    <= st_busy;
					end else if (stable_r && rx_go) begin
						xfer_start <= 1'b1;
						xfer       <= '{rx: 1'b1, len: rx_need};
						state_r    <= st_busy;
					end
				end
				st_busy: begin
					if (xfer_done)
						state_r <= st_idle;
				end
				default: state_r <= st_idle;
			endcase
		end
	end

	// ****************************************************************
	// Threshold conditions
	// ****************************************************************
	assign tx_irq_cond = (tx_free8 > tx_irq_threshold_r);
	assign rx_irq_cond = (rx_cnt8 >= rx_irq_threshold_r);

	// A set in the same cycle as a clear wins.
	always_ff @(posedge clk) begin
		if (rst)
			tx_threshold_flag <= 1'b0;
		else
			tx_threshold_flag <= tx_irq_cond || (tx_threshold_flag && !tx_flag_clr);
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [11:0] gap_r;

	always_ff @(posedge clk) begin
		if (rst || !clk_en_r || clkcon_wr || serial_clock_tick)
			gap_r <= '0;
		else
			gap_r <= gap_r + 12'h1;
	end

	// Receive occupancy rebuilt from the two handshakes, independent of the FIFO's own count.
	logic [7:0] rx_occ_r;

	always_ff @(posedge clk) begin
		if (rst)
			rx_occ_r <= '0;
		else if ((link_rx_valid && link_rx_ready) && !(sw_rx_valid && sw_rx_ready))
			rx_occ_r <= rx_occ_r + 8'h01;
		else if (!(link_rx_valid && link_rx_ready) && (sw_rx_valid && sw_rx_ready))
			rx_occ_r <= rx_occ_r - 8'h01;
	end

	default clocking cc @(posedge clk); endclocking
	default disable iff (rst);

	a_div_tick_period: assert property (serial_clock_tick |-> gap_r == 12'(div_lim))
		else $error("Serial tick spacing does not match the divider.");
	a_nodiv_every_cycle: assert property (clk_en_r && serial_clock_divider_r == '0 && !clkcon_wr
		|=> serial_clock_tick)
		else $error("Undivided rate missed a cycle.");
	a_stable_rise: assert property ($rose(stable_r) |-> clk_en_r && $past(serial_clock_tick))
		else $error("Stable flag rose without an enabled clock.");
	a_off_no_tick: assert property (!clk_en_r |-> !serial_clock_tick)
		else $error("Serial tick while the clock is disabled.");
	a_rd_cmdthr: assert property (reg_req.rd && reg_req.idx == `QSC_IDX_CMDTHR
		|=> reg_rdata == {16'h0, $past(tx_command_threshold_r), $past(rx_command_threshold_r)})
		else $error("Command threshold readback is wrong.");
	a_tx_start_cond: assert property (xfer_start && !xfer.rx
		|-> $past(mode == mode_tx && tx_cnt8 >= tx_command_threshold_r))
		else $error("Transmit started below threshold.");
	a_rx_len_room: assert property (xfer_start && xfer.rx
		|-> xfer.len == $past(rx_need) && $past(rx_free8) >= xfer.len)
		else $error("Receive length or room is wrong.");
	a_rx_irq_level: assert property (rx_irq_cond == (rx_occ_r >= rx_irq_threshold_r))
		else $error("Receive threshold condition missing.");
	a_clkcon_zero: assert property (reg_req.rd && reg_req.idx == `QSC_IDX_CLKCON
		|=> reg_rdata[31:19] == '0 && reg_rdata[7:2] == '0)
		else $error("Unimplemented clock control bits read nonzero.");
	a_idle_no_start: assert property (mode != mode_tx && mode != mode_rx |=> !xfer_start)
		else $error("Transfer started outside an initiating mode.");
	a_txflag_set: assert property (tx_irq_cond |=> tx_threshold_flag)
		else $error("Transmit threshold flag not set.");
	a_stable_clear: assert property (!clk_en_r |-> !stable_r)
		else $error("Stable flag set while the clock is disabled.");

	c_tx_start: cover property (xfer_start && !xfer.rx);
	c_rx_start: cover property (xfer_start && xfer.rx);
	c_stable: cover property ($rose(stable_r));
	c_rx_full: cover property (rx_cnt8 == DEPTH8 && link_rx_valid);

endmodule // qsc_ctrl

// >>> design/qsc_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides and an occupancy count.
// Assumes: Synchronous active-high reset; there is no separate clear.
// Notes:   Full and empty are exact; out_data is read from storage by index.
`timescale 1ns/1ps
`include "qsc_map.svh"
module qsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `QSC_FIFO_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [CW-1:0]         count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [CW-1:0]    cnt_r;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != CW'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rp_r];
	assign count     = cnt_r;

	always_ff @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	default clocking fc @(posedge clk); endclocking
	default disable iff (rst);

	a_fifo_no_over: assert property (!in_ready |=> cnt_r == CW'(DEPTH) || $past(pop))
		else $error("FIFO count changed while full without a pop.");

endmodule // qsc_fifo

// >>> design/qsc_map.svh
// Purpose: Register indices, field positions and counts of the serial clock and threshold block.
// Assumes: Included by every design file that decodes registers.
// Notes:   Registers are word indices on the block's register port.
`ifndef QSC_MAP_SVH
`define QSC_MAP_SVH

`define QSC_IDX_CLKCON   2'h0
`define QSC_IDX_CMDTHR   2'h1
`define QSC_IDX_INTTHR   2'h2
`define QSC_EN_BIT       0
`define QSC_STABLE_BIT   1
`define QSC_DIV_LSB      8
`define QSC_DIV_MSB      18
`define QSC_DIV_W        11
`define QSC_HI_LSB       8
`define QSC_HI_MSB       15
`define QSC_LO_LSB       0
`define QSC_LO_MSB       7
`define QSC_RESET_WORD   32'h0000_0000
`define QSC_SETTLE_TICKS 4
`define QSC_FIFO_DEPTH   8

`endif

// >>> design/qsc_pkg.sv
// Purpose: Types shared by the serial clock and threshold block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Mode codes follow declaration order: idle, transmit, receive, reserved.
package qsc_pkg;

	typedef enum logic [1:0] {mode_idle, mode_tx, mode_rx, mode_rsvd} qsc_mode_t;

	typedef enum logic {st_idle, st_busy} qsc_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [1:0]  idx;
		logic [31:0] wdata;
	} qsc_reg_req_t;

	typedef struct packed {
		logic       rx;
		logic [7:0] len;
	} qsc_xfer_t;

endpackage

// >>> tb/qsc_flash_model.sv
// Purpose: Behavioural flash engine that drains the TX FIFO and fills the RX FIFO.
// Assumes: Requests arrive as one-cycle xfer_start pulses with xfer held.
// Notes:   slow adds a gap between bytes; released data shows the inverse of the last byte.
`timescale 1ns/1ps
// ****************************************
// Flash engine model
// ****************************************
module qsc_flash_model #(
	parameter logic [7:0] RX_FIRST = 8'h5A
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          slow,
	input  qsc_pkg::qsc_xfer_t xfer,
	input  wire logic          xfer_start,
	output logic               xfer_done,
	input  wire logic          link_tx_valid,
	output logic               link_tx_ready,
	output logic               link_rx_valid,
	input  wire logic          link_rx_ready,
	output logic [7:0]         link_rx_data
);
	import qsc_pkg::*;
	logic [7:0] left_r;
	logic       is_rx_r;
	logic       gap_r;
	logic [7:0] seq_r;
	logic       beat;
	assign beat = (link_tx_valid && link_tx_ready) || (link_rx_valid && link_rx_ready);
	always_ff @(posedge clk) begin
		if (rst) begin
			left_r        <= 8'h00;
			is_rx_r       <= 1'b0;
			gap_r         <= 1'b0;
			seq_r         <= RX_FIRST;
			xfer_done     <= 1'b0;
			link_tx_ready <= 1'b0;
			link_rx_valid <= 1'b0;
			link_rx_data  <= 8'h00;
		end else begin
			xfer_done <= 1'b0;
			gap_r     <= ~gap_r;
			if (xfer_start) begin
				left_r  <= xfer.len;
				is_rx_r <= xfer.rx;
			end else if (beat) begin
				link_tx_ready <= 1'b0;
				link_rx_valid <= 1'b0;
				link_rx_data  <= ~link_rx_data;
				left_r        <= left_r - 8'h01;
				xfer_done     <= (left_r == 8'h01);
				if (is_rx_r) seq_r <= seq_r + 8'h01;
			end else if (left_r != 8'h00 && (!slow || gap_r)) begin
				link_tx_ready <= !is_rx_r;
				link_rx_valid <= is_rx_r;
				if (is_rx_r) link_rx_data <= seq_r;
			end
		end
	end
endmodule // qsc_flash_model

// >>> tb/quad_serial_clock_threshold_ctrl_tb_top.sv
// Purpose: Self-checking bench for the serial clock and threshold block.
// Assumes: Design files compiled first; registers reached through the word-indexed port.
// Notes:   Random data comes from a fixed seed so every run repeats.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e), (g) === (e))
// ****************************************
// Bench top
// ****************************************
module quad_serial_clock_threshold_ctrl_tb_top;
	import qsc_pkg::*;
	localparam int SETTLE = 4;
	localparam int LIMIT  = 40000;
	logic          clk = 1'b0, rst = 1'b1, tx_flag_clr = 1'b0, slow = 1'b0;
	qsc_reg_req_t  req = '0;
	logic [1:0]    mode = 2'b00;
	logic          sw_tx_valid = 1'b0, sw_rx_ready = 1'b0;
	logic [7:0]    sw_tx_data = 8'h00, link_tx_data, link_rx_data, sw_rx_data, rx_exp = 8'h5A, b;
	logic [31:0]   reg_rdata, v;
	logic          serial_clock_tick, clock_stable, xfer_start, xfer_done, tx_threshold_flag;
	logic          tx_irq_cond, rx_irq_cond, sw_tx_ready, link_tx_valid, link_tx_ready;
	logic          link_rx_valid, link_rx_ready, sw_rx_valid;
	qsc_xfer_t     xfer, last_xfer;
	int            mismatches = 0, tests_run = 0, cycles = 0, starts = 0, s0, n, tr, tt;
	int            seed = 32'h16b7;
	logic [7:0]    got_q[$], exp_q[$];

	qsc_ctrl #(.DEPTH(8), .SETTLE(SETTLE)) dut (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
		.command_initiation_mode(mode), .serial_clock_tick(serial_clock_tick), .clock_stable(clock_stable),
		.xfer(xfer), .xfer_start(xfer_start), .xfer_done(xfer_done), .tx_flag_clr(tx_flag_clr),
		.tx_threshold_flag(tx_threshold_flag), .tx_irq_cond(tx_irq_cond), .rx_irq_cond(rx_irq_cond),
		.sw_tx_valid(sw_tx_valid), .sw_tx_ready(sw_tx_ready), .sw_tx_data(sw_tx_data),
		.link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready), .link_tx_data(link_tx_data),
		.link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready), .link_rx_data(link_rx_data),
		.sw_rx_valid(sw_rx_valid), .sw_rx_ready(sw_rx_ready), .sw_rx_data(sw_rx_data));
	qsc_flash_model flash (.clk(clk), .rst(rst), .slow(slow), .xfer(xfer), .xfer_start(xfer_start),
		.xfer_done(xfer_done), .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready),
		.link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready), .link_rx_data(link_rx_data));

	always #10 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (xfer_start === 1'b1) begin
			starts    <= starts + 1;
			last_xfer <= xfer;
		end
		if (link_tx_valid === 1'b1 && link_tx_ready === 1'b1) got_q.push_back(link_tx_data);
		if (cycles == LIMIT) begin
			mismatches++;
			close_out();
		end
	end

	function automatic int period(input int k);
		return (k < 0) ? 1 : (2 ** (k + 1));
	endfunction

	task automatic check_val(input logic [31:0] g, input logic [31:0] e, input bit ok);
		tests_run++;
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("Checks made %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [1:0] i, input logic [31:0] d);
		req <= '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask

	task automatic reg_rd_chk(input logic [1:0] i, input logic [31:0] e);
		req <= '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 32'h0000_0000};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		`CHK(reg_rdata, e);
	endtask

	task automatic push(input logic [7:0] d);
		int k;
		k = 0;
		sw_tx_valid <= 1'b1;
		sw_tx_data  <= d;
		exp_q.push_back(d);
		do @(posedge clk); while (sw_tx_ready !== 1'b1 && ++k < 50);
		sw_tx_valid <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pop_chk();
		int k;
		logic [7:0] d;
		k = 0;
		sw_rx_ready <= 1'b1;
		do @(posedge clk); while (sw_rx_valid !== 1'b1 && ++k < 50);
		d = sw_rx_data;
		sw_rx_ready <= 1'b0;
		@(posedge clk);
		`CHK(d, rx_exp);
		rx_exp = rx_exp + 8'h01;
	endtask

	task automatic wait_tick();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (serial_clock_tick !== 1'b1 && n < 5000);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 4; i++) reg_rd_chk(2'(i), 32'h0000_0000);
		reg_wr(2'h0, 32'hFFFF_FFFE);
		reg_rd_chk(2'h0, 32'h0007_FF00);
		for (int i = 1; i < 4; i++) begin
			v = $random(seed);
			reg_wr(2'(i), v);
			reg_rd_chk(2'(i), (i == 3) ? 32'h0 : (v & 32'h0000_FFFF));
		end
		$display("Register test finished");
		for (int k = -1; k < 11; k++) begin
			v = (k < 0) ? 32'h1 : ((32'h1 << (k + 8)) | 32'h1);
			reg_wr(2'h0, 32'h0000_0000);
			`CHK(clock_stable, 1'b0);
			n = 0;
			repeat (8) begin
				@(posedge clk);
				if (serial_clock_tick !== 1'b0) n++;
			end
			`CHK(n, 0);
			reg_wr(2'h0, v);
			wait_tick();
			wait_tick();
			`CHK(n, period(k));
			repeat (SETTLE * period(k)) @(posedge clk);
			`CHK(clock_stable, 1'b1);
			reg_rd_chk(2'h0, v | 32'h2);
		end
		reg_wr(2'h0, 32'h0000_0001);
		repeat (SETTLE + 3) @(posedge clk);
		$display("Divider test finished");
		reg_wr(2'h1, 32'h0000_0300);
		mode <= 2'b01;
		s0 = starts;
		repeat (2) push(8'($random(seed)));
		repeat (10) @(posedge clk);
		`CHK(starts - s0, 0);
		push(8'($random(seed)));
		repeat (4) @(posedge clk);
		`CHK(starts - s0, 1);
		`CHK(last_xfer, 9'h003);
		repeat (20) @(posedge clk);
		`CHK(got_q.size(), 3);
		foreach (exp_q[i]) `CHK(got_q[i], exp_q[i]);
		mode <= 2'b00;
		$display("Transmit test finished");
		slow <= 1'b1;
		reg_wr(2'h1, 32'h0000_0005);
		mode <= 2'b10;
		s0 = starts;
		repeat (40) @(posedge clk);
		`CHK(starts - s0, 1);
		`CHK(last_xfer, 9'h105);
		for (int i = 0; i < 6; i++) begin
			tr = (i < 2) ? 5 + i : ($unsigned($random(seed)) % 10);
			tt = (i < 2) ? 7 + i : ($unsigned($random(seed)) % 10);
			reg_wr(2'h2, 32'((tt << 8) | tr));
			`CHK(rx_irq_cond, 1'(5 >= tr));
			`CHK(tx_irq_cond, 1'(8 > tt));
		end
		reg_wr(2'h2, 32'h0000_0800);
		tx_flag_clr <= 1'b1;
		@(posedge clk);
		tx_flag_clr <= 1'b0;
		@(posedge clk);
		`CHK(tx_threshold_flag, 1'b0);
		reg_wr(2'h2, 32'h0000_0700);
		@(posedge clk);
		`CHK(tx_threshold_flag, 1'b1);
		mode <= 2'b00;
		s0 = starts;
		repeat (2) pop_chk();
		`CHK(starts - s0, 0);
		mode <= 2'b10;
		repeat (20) @(posedge clk);
		`CHK(starts - s0, 1);
		`CHK(last_xfer, 9'h102);
		mode <= 2'b00;
		repeat (5) pop_chk();
		`CHK(starts - s0, 1);
		for (int m = 0; m < 4; m++) begin
			mode <= 2'b00;
			reg_wr(2'h1, (m == 2) ? 32'h0000_000A : 32'h0000_0005);
			mode <= 2'(m);
			repeat (12) @(posedge clk);
			`CHK(starts - s0, 1);
		end
		$display("Receive test finished");
		close_out();
	end
endmodule // quad_serial_clock_threshold_ctrl_tb_top
